// [bench/irq_redirect_regs_props.sv]
// concurrent checks on the redirection register block ports
`timescale 1ns/1ps
module irq_redirect_regs_props (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // register access
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // interrupts and messages
    input wire logic [23:0] irq_pin_i,
    input wire irq_redirect_pkg::msg_write_t msg_o,
    input wire logic msg_ready_i
);
    logic [7:0] sel;
    logic win_rd;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // shadow of the select pointer, so window reads can be judged
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sel <= 8'h00;
        end else if (reg_wr_i && reg_addr_i == irq_redirect_pkg::ADDR_SELECT_POINTER) begin
            sel <= reg_wdata_i[7:0];
        end
    end
    assign win_rd = reg_rd_i && reg_addr_i == irq_redirect_pkg::ADDR_DATA_WINDOW;
    a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read unanswered");
    a_idle_rdata: assert property (!reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 32'h0000_0000)
        else $error("data without read");
    a_version_word: assert property (win_rd && sel == 8'h01 |=>
        reg_rdata_o == {24'h00_1700, irq_redirect_pkg::VERSION_CODE}) else $error("version word");
    a_id_reserved: assert property (win_rd && sel == 8'h00 |=> (reg_rdata_o & 32'hF0FF_7FFF) == 32'h0000_0000)
        else $error("number register reserved bits");
    a_entry_high_zero: assert property (win_rd && sel inside {[8'h10:8'h3F]} && sel[0] |=>
        reg_rdata_o[15:0] == 16'h0000) else $error("entry high reserved");
    a_entry_low_zero: assert property (win_rd && sel inside {[8'h10:8'h3F]} && !sel[0] |=>
        reg_rdata_o[31:17] == 15'h0000) else $error("entry low reserved");
    a_reserved_index: assert property (win_rd && sel inside {[8'h02:8'h0F], [8'h40:8'hFF]} |=>
        reg_rdata_o == 32'h0000_0000) else $error("reserved index");
    a_msg_held: assert property (msg_o.valid && !msg_ready_i |=> msg_o.valid && $stable(msg_o))
        else $error("message dropped");
    a_msg_format: assert property (msg_o.valid |-> msg_o.addr[31:20] == 12'hFEE && msg_o.addr[3] == 1'b0 &&
        msg_o.addr[1:0] == 2'b00 && msg_o.data[31:16] == 16'h0000 && msg_o.data[14:11] == 4'h0)
        else $error("message format");
endmodule

bind irq_redirect_regs irq_redirect_regs_props u_props (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .irq_pin_i(irq_pin_i), .msg_o(msg_o),
    .msg_ready_i(msg_ready_i));

// [bench/msg_sink.sv]
// model of the local controllers that take message writes
`timescale 1ns/1ps
module msg_sink (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // message link
    input wire irq_redirect_pkg::msg_write_t msg_i,
    output logic msg_ready_o,
    // observed traffic
    output int unsigned taken_o,
    output logic [31:0] last_addr_o,
    output logic [31:0] last_data_o
);
    // random stalls, so a waiting message has to be held
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            msg_ready_o <= 1'b0;
            taken_o <= 0;
        end else begin
            if (msg_i.valid && msg_ready_o) begin
                taken_o <= taken_o + 1;
                last_addr_o <= msg_i.addr;
                last_data_o <= msg_i.data;
            end
            msg_ready_o <= ($urandom % 3) != 0;
        end
    end
endmodule

// [bench/tb_irq_redirect_regs.sv]
// self-checking bench for the interrupt redirection register block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected at %0t: got %h want %h", $time, (got), (exp)); end end
module tb_irq_redirect_regs;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic [31:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic [23:0] irq_pin_i = 24'h00_0000;
    irq_redirect_pkg::msg_write_t msg_o;
    logic msg_ready_i;
    int unsigned taken;
    logic [31:0] last_addr;
    logic [31:0] last_data;
    logic [31:0] rd_val;
    int err_total = 0;
    int checks = 0;
    irq_redirect_regs u_irq_redirect_regs (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .irq_pin_i(irq_pin_i), .msg_o(msg_o), .msg_ready_i(msg_ready_i));
    msg_sink u_msg_sink (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .msg_i(msg_o), .msg_ready_o(msg_ready_i),
        .taken_o(taken), .last_addr_o(last_addr), .last_data_o(last_data));
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task automatic acc(input logic rd, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        #1;
        reg_rd_i = rd;
        reg_wr_i = !rd;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge ref_clk_i);
        #1;
        reg_rd_i = 1'b0;
        reg_wr_i = 1'b0;
        rd_val = reg_rdata_o;
        if (rd) `CHK(reg_rvalid_o, 1'b1)
    endtask
    task automatic ireg(input logic rd, input logic [7:0] idx, input logic [31:0] d);
        acc(1'b0, irq_redirect_pkg::ADDR_SELECT_POINTER, {24'h00_0000, idx});
        acc(rd, irq_redirect_pkg::ADDR_DATA_WINDOW, d);
    endtask
    task automatic chk_ireg(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] exp);
        ireg(1'b1, idx, 32'h0000_0000);
        `CHK(rd_val & m, exp)
    endtask
    task automatic wait_msg(input int unsigned n);
        for (int i = 0; i < 40 && taken != n; i++) begin
            @(posedge ref_clk_i);
            #1;
        end
        `CHK(taken, n)
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        conclude();
    end
    initial begin
        logic [31:0] hi;
        logic [31:0] lo;
        logic [31:0] vs;
        logic [7:0] v;
        logic [2:0] t;
        int unsigned n;
        int unsigned e;
        vs = {24'h00_1700, irq_redirect_pkg::VERSION_CODE};
        void'($urandom(32'h8046b2d7));
        repeat (2) @(posedge ref_clk_i);
        #1;
        reset_i = 1'b0;
        chk_ireg(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
        chk_ireg(8'h01, 32'hFFFF_FFFF, vs);
        for (int k = 0; k < 48; k++) chk_ireg(8'h10 + 8'(k), 32'hFFFF_FFFF, k[0] ? 32'h0 : 32'h0001_0000);
        ireg(1'b0, 8'h00, 32'hFFFF_FFFF);
        chk_ireg(8'h00, 32'hFFFF_FFFF, 32'h0F00_8000);
        ireg(1'b0, 8'h01, 32'hFFFF_FFFF);
        chk_ireg(8'h01, 32'hFFFF_FFFF, vs);
        ireg(1'b0, 8'h40, 32'hFFFF_FFFF);
        chk_ireg(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        acc(1'b0, 8'h20, 32'hFFFF_FFFF);
        acc(1'b1, 8'h20, 32'h0000_0000);
        `CHK(rd_val, 32'h0000_0000)
        n = taken;
        irq_pin_i = 24'($urandom);
        for (int k = 0; k < 24; k++) begin
            hi = $urandom;
            lo = $urandom | 32'h0001_0000;
            ireg(1'b0, 8'h11 + 8'(2 * k), hi);
            ireg(1'b0, 8'h10 + 8'(2 * k), lo);
            chk_ireg(8'h11 + 8'(2 * k), 32'hFFFF_FFFF, hi & 32'hFFFF_0000);
            chk_ireg(8'h10 + 8'(2 * k), 32'hFFFF_BFFF, lo & 32'h0001_AFFF);
        end
        `CHK(taken, n)
        irq_pin_i = 24'h00_0000;
        for (int k = 0; k < 6; k++) begin
            e = 4 * k;
            t = (k % 3 == 2) ? irq_redirect_pkg::DLV_EXTERNAL : 3'(k % 3);
            v = 8'h10 + 8'($urandom % 239);
            hi = $urandom & 32'hFFFF_0000;
            lo = {18'h0_0000, k[0], 1'b0, k[1], t, v};
            irq_pin_i[e] = k[0];
            ireg(1'b0, 8'h11 + 8'(2 * e), hi);
            ireg(1'b0, 8'h10 + 8'(2 * e), lo);
            n = taken;
            irq_pin_i[e] = !k[0];
            wait_msg(n + 1);
            `CHK(last_addr, irq_redirect_pkg::FIXED_WINDOW_BASE | {12'h000, hi[31:16], 1'b0, k[1], 2'b00})
            `CHK(last_data, {21'h00_0000, t, v})
            irq_pin_i[e] = k[0];
        end
        v = 8'h10 + 8'($urandom % 239);
        for (int k = 22; k < 24; k++) begin
            ireg(1'b0, 8'h11 + 8'(2 * k), 32'h0000_0000);
            ireg(1'b0, 8'h10 + 8'(2 * k), 32'h0000_8000 | 32'(v));
        end
        n = taken;
        irq_pin_i[23:22] = 2'b11;
        wait_msg(n + 2);
        `CHK(last_data, 32'h0000_8000 | 32'(v))
        chk_ireg(8'h3E, 32'h0000_4000, 32'h0000_4000);
        repeat (20) @(posedge ref_clk_i);
        #1;
        `CHK(taken, n + 2)
        irq_pin_i[23:22] = 2'b00;
        acc(1'b0, irq_redirect_pkg::ADDR_END_OF_INTERRUPT, {24'h00_0000, v ^ 8'h01});
        chk_ireg(8'h3C, 32'h0000_4000, 32'h0000_4000);
        acc(1'b0, irq_redirect_pkg::ADDR_END_OF_INTERRUPT, {24'h00_0000, v});
        chk_ireg(8'h3C, 32'h0000_4000, 32'h0000_0000);
        chk_ireg(8'h3E, 32'h0000_4000, 32'h0000_0000);
        n = taken;
        ireg(1'b0, 8'h3A, 32'h0000_8700 | 32'(v));
        irq_pin_i[21] = 1'b1;
        wait_msg(n + 1);
        chk_ireg(8'h3A, 32'h0000_4000, 32'h0000_0000);
        // a second excluded type, so the decode is not judged on one code alone
        ireg(1'b0, 8'h3A, 32'h0000_8200 | 32'(v));
        n = taken;
        wait_msg(n + 2);
        chk_ireg(8'h3A, 32'h0000_4000, 32'h0000_0000);
        ireg(1'b0, 8'h3A, 32'h0001_8700 | 32'(v));
        irq_pin_i[21] = 1'b0;
        conclude();
    end
endmodule

// [rtl/irq_input_sync.sv]
// two-flop synchroniser and active-level detector for the interrupt inputs
`timescale 1ns/1ps
module irq_input_sync (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // raw inputs and polarity
    input wire logic [23:0] irq_pin_i,
    input wire logic [23:0] active_low_i,
    // detected activity
    output logic [23:0] level_o,
    output logic [23:0] rise_o
);
    typedef struct packed {
        logic [23:0] meta;
        logic [23:0] sync;
        logic [23:0] last;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.meta = irq_pin_i;
        next_st.sync = st.meta;
        next_st.last = st.sync ^ active_low_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // polarity applied after synchronising, so a polarity change can show as one edge
    assign level_o = st.sync ^ active_low_i; // [R15]
    assign rise_o = level_o & ~st.last;
endmodule

// [rtl/irq_redirect_pkg.sv]
// package for the interrupt redirection register block
package irq_redirect_pkg;
    localparam int NUM_INPUTS = 24;
    localparam logic [7:0] IDX_CONTROLLER_NUMBER = 8'h00;
    localparam logic [7:0] IDX_CONTROLLER_VERSION = 8'h01;
    localparam logic [7:0] IDX_ENTRY_FIRST = 8'h10;
    localparam logic [7:0] IDX_ENTRY_LAST = 8'h3F;
    localparam logic [7:0] HIGHEST_ENTRY_INDEX = 8'h17;
    // implementation version code: arbitrary value
    localparam logic [7:0] VERSION_CODE = 8'h5A;
    localparam logic [31:0] REG_ZERO = 32'h0000_0000;
    localparam logic [31:0] FIXED_WINDOW_BASE = 32'hFEE0_0000;
    // window register addresses (memory-space offsets of the three access registers)
    localparam logic [7:0] ADDR_SELECT_POINTER = 8'h00;
    localparam logic [7:0] ADDR_DATA_WINDOW = 8'h10;
    localparam logic [7:0] ADDR_END_OF_INTERRUPT = 8'h40;
    // delivery type encodings
    localparam logic [2:0] DLV_FIXED = 3'b000;
    localparam logic [2:0] DLV_LOWEST = 3'b001;
    localparam logic [2:0] DLV_SYS_MGMT = 3'b010;
    localparam logic [2:0] DLV_NON_MASKABLE = 3'b100;
    localparam logic [2:0] DLV_INIT = 3'b101;
    localparam logic [2:0] DLV_EXTERNAL = 3'b111;

    typedef struct packed {
        logic [7:0] target_core_id;
        logic [7:0] target_core_id_ext;
        logic entry_inhibit;
        logic trigger_level_select;
        logic level_inflight_flag;
        logic input_active_low;
        logic delivery_pending;
        logic destination_addressing;
        logic [2:0] delivery_type;
        logic [7:0] interrupt_vector;
    } routing_entry_t;

    localparam routing_entry_t ENTRY_RESET = '{entry_inhibit: 1'b1, default: '0};

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
    } msg_write_t;

    function automatic logic [31:0] pack_low(input routing_entry_t e);
        pack_low = {15'h0000, e.entry_inhibit, e.trigger_level_select, e.level_inflight_flag,
                    e.input_active_low, e.delivery_pending, e.destination_addressing,
                    e.delivery_type, e.interrupt_vector};
    endfunction

    function automatic logic no_inflight_type(input logic [2:0] t);
        no_inflight_type = (t == DLV_SYS_MGMT) || (t == DLV_NON_MASKABLE) ||
                           (t == DLV_INIT) || (t == DLV_EXTERNAL);
    endfunction
endpackage

// [rtl/irq_redirect_regs.sv]
// interrupt redirection controller: index/window registers, routing entries, message writer
//
// Functional notes
// [R01] index 0 holds 4-bit controller number, bits 27:24
// [R02] bit 15 scratch, bit 14 ignored, rest zero
// [R03] version register index 1, read-only
// [R04] version bits 23:16 give highest entry 17h
// [R05] version bit 15 reads zero
// [R06] version bits 7:0 fixed version code
// [R07] 24 entries, two halves at 10h-3Fh
// [R08] target ids in 63:48, 47:17 read zero
// [R09] inhibit resets set, blocks delivery and pending
// [R10] unmasked entry delivers on configured edge/level
// [R11] bit 15 selects edge or level detection
// [R12] in-flight flag set on level message send
// [R13] matching end-of-interrupt clears in-flight flag
// [R14] no in-flight for smi, nmi, init, external
// [R15] bit 13 sets input polarity active low
// [R16] bit 12 read-only pending, not yet delivered
// [R17] destination addressing bit carried in message
// [R18] bits 10:8 select delivery type
// [R19] software keeps vector within 10h to FEh
// [R20] end-of-interrupt clears all matching entries
// [R21] index selects register seen in data window
// [R22] message is 32-bit write to target
// [R23] in-flight level entry waits for end-of-interrupt
`timescale 1ns/1ps
module irq_redirect_regs (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // memory-space register access
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // interrupt inputs
    input wire logic [23:0] irq_pin_i,
    // message write to local controllers
    output irq_redirect_pkg::msg_write_t msg_o,
    input wire logic msg_ready_i
);
    localparam int N = irq_redirect_pkg::NUM_INPUTS;

    typedef struct packed {
        logic [7:0] select_pointer;
        logic [3:0] controller_number_field;
        logic scratch;
        irq_redirect_pkg::routing_entry_t [N-1:0] entry;
        logic [23:0] edge_seen;
        logic [4:0] rr_ptr;
        logic [31:0] rdata;
        logic rvalid;
        irq_redirect_pkg::msg_write_t msg;
        logic [4:0] msg_src;
    } regs_state_t;

    regs_state_t st;
    regs_state_t next_st;
    logic [23:0] active_low;
    logic [23:0] level_active;
    logic [23:0] rise;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            active_low[i] = st.entry[i].input_active_low;
        end
    end

    irq_input_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .irq_pin_i(irq_pin_i),
        .active_low_i(active_low),
        .level_o(level_active),
        .rise_o(rise)
    );

    function automatic logic [31:0] window_read(input regs_state_t s);
        logic [5:0] rel;
        logic [4:0] ei;
        window_read = irq_redirect_pkg::REG_ZERO;
        rel = 6'(s.select_pointer - irq_redirect_pkg::IDX_ENTRY_FIRST);
        ei = rel[5:1];
        if (s.select_pointer == irq_redirect_pkg::IDX_CONTROLLER_NUMBER) begin
            window_read = {4'h0, s.controller_number_field, 8'h00, s.scratch, 15'h0000}; // [R01] [R02]
        end else if (s.select_pointer == irq_redirect_pkg::IDX_CONTROLLER_VERSION) begin
            window_read = {8'h00, irq_redirect_pkg::HIGHEST_ENTRY_INDEX, 1'b0, 7'h00,
                           irq_redirect_pkg::VERSION_CODE}; // [R03] [R04] [R05] [R06]
        end else if (s.select_pointer >= irq_redirect_pkg::IDX_ENTRY_FIRST &&
                     s.select_pointer <= irq_redirect_pkg::IDX_ENTRY_LAST) begin
            if (rel[0]) begin
                window_read = {s.entry[ei].target_core_id, s.entry[ei].target_core_id_ext, 16'h0000}; // [R08]
            end else begin
                window_read = irq_redirect_pkg::pack_low(s.entry[ei]); // [R07]
            end
        end
    endfunction

    always_comb begin
        logic [5:0] rel;
        logic [4:0] ei;
        logic win_wr;
        logic eoi_wr;
        logic [23:0] want;
        logic found;
        logic [4:0] pick;
        rel = '0;
        ei = '0;
        win_wr = reg_wr_i && (reg_addr_i == irq_redirect_pkg::ADDR_DATA_WINDOW);
        eoi_wr = reg_wr_i && (reg_addr_i == irq_redirect_pkg::ADDR_END_OF_INTERRUPT);
        want = '0;
        found = 1'b0;
        pick = '0;
        next_st = st;
        next_st.rvalid = reg_rd_i;
        next_st.rdata = irq_redirect_pkg::REG_ZERO;

        // register reads
        if (reg_rd_i) begin
            if (reg_addr_i == irq_redirect_pkg::ADDR_SELECT_POINTER) begin
                next_st.rdata = {24'h00_0000, st.select_pointer};
            end else if (reg_addr_i == irq_redirect_pkg::ADDR_DATA_WINDOW) begin
                next_st.rdata = window_read(st); // [R21]
            end
        end

        // edge capture: inhibited entries remember nothing
        for (int i = 0; i < N; i++) begin
            if (st.entry[i].entry_inhibit) begin
                next_st.edge_seen[i] = 1'b0; // [R09]
            end else if (!st.entry[i].trigger_level_select && rise[i]) begin
                next_st.edge_seen[i] = 1'b1; // [R11]
            end
        end

        // register writes
        if (reg_wr_i && reg_addr_i == irq_redirect_pkg::ADDR_SELECT_POINTER) begin
            next_st.select_pointer = reg_wdata_i[7:0]; // [R21]
        end
        if (win_wr) begin
            rel = 6'(st.select_pointer - irq_redirect_pkg::IDX_ENTRY_FIRST);
            ei = rel[5:1];
            if (st.select_pointer == irq_redirect_pkg::IDX_CONTROLLER_NUMBER) begin
                next_st.controller_number_field = reg_wdata_i[27:24]; // [R01]
                next_st.scratch = reg_wdata_i[15]; // [R02]
            end else if (st.select_pointer >= irq_redirect_pkg::IDX_ENTRY_FIRST &&
                         st.select_pointer <= irq_redirect_pkg::IDX_ENTRY_LAST) begin
                if (rel[0]) begin
                    next_st.entry[ei].target_core_id = reg_wdata_i[31:24]; // [R08]
                    next_st.entry[ei].target_core_id_ext = reg_wdata_i[23:16];
                end else begin
                    // pending and in-flight are hardware-owned; writes leave them alone
                    next_st.entry[ei].entry_inhibit = reg_wdata_i[16];
                    next_st.entry[ei].trigger_level_select = reg_wdata_i[15];
                    next_st.entry[ei].input_active_low = reg_wdata_i[13];
                    next_st.entry[ei].destination_addressing = reg_wdata_i[11];
                    next_st.entry[ei].delivery_type = reg_wdata_i[10:8]; // [R18]
                    next_st.entry[ei].interrupt_vector = reg_wdata_i[7:0];
                end
            end
        end

        // end-of-interrupt clears every matching entry
        if (eoi_wr) begin
            for (int i = 0; i < N; i++) begin
                if (st.entry[i].interrupt_vector == reg_wdata_i[7:0]) begin
                    next_st.entry[i].level_inflight_flag = 1'b0; // [R13] [R20]
                end
            end
        end

        // pending status per entry
        for (int i = 0; i < N; i++) begin
            if (st.entry[i].trigger_level_select) begin
                want[i] = level_active[i] && !st.entry[i].level_inflight_flag; // [R23]
            end else begin
                want[i] = st.edge_seen[i];
            end
            want[i] = want[i] && !st.entry[i].entry_inhibit; // [R09] [R10]
            next_st.entry[i].delivery_pending = want[i]; // [R16]
        end

        // message handshake
        if (st.msg.valid && msg_ready_i) begin
            next_st.msg.valid = 1'b0;
        end
        if (!st.msg.valid || msg_ready_i) begin
            for (int k = 0; k < N; k++) begin
                if (!found && want[5'((32'(st.rr_ptr) + k) % N)]) begin
                    found = 1'b1;
                    pick = 5'((32'(st.rr_ptr) + k) % N);
                end
            end
            if (found) begin
                next_st.msg.valid = 1'b1;
                // address carries target ids and addressing mode, data carries type and vector
                next_st.msg.addr = irq_redirect_pkg::FIXED_WINDOW_BASE |
                                   {12'h000, st.entry[pick].target_core_id, st.entry[pick].target_core_id_ext,
                                    1'b0, st.entry[pick].destination_addressing, 2'b00}; // [R22] [R17]
                next_st.msg.data = {16'h0000, st.entry[pick].trigger_level_select, 4'h0,
                                    st.entry[pick].delivery_type, st.entry[pick].interrupt_vector}; // [R22]
                next_st.msg_src = pick;
                next_st.rr_ptr = (pick == 5'(N - 1)) ? 5'd0 : pick + 5'd1;
                next_st.entry[pick].delivery_pending = 1'b0;
                if (!st.entry[pick].trigger_level_select) begin
                    next_st.edge_seen[pick] = rise[pick];
                end else if (!irq_redirect_pkg::no_inflight_type(st.entry[pick].delivery_type)) begin
                    next_st.entry[pick].level_inflight_flag = 1'b1; // [R12] [R14]
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st <= '0;
            for (int i = 0; i < N; i++) begin
                st.entry[i] <= irq_redirect_pkg::ENTRY_RESET; // [R09]
            end
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o = st.rdata;
    assign reg_rvalid_o = st.rvalid;
    assign msg_o = st.msg;
endmodule
